// ---- variable_length_serial_io_tb.sv ----
module variable_length_serial_io_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, sys_rst, clkEn, psel, penable, pwrite, sckIn, linkClk, armed;
   logic pready, pslverr, transferDoneIrq, sckOut, sckOeN, siIn, soOut, soOeN;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [6:0] peerFmt;
   logic [15:0] peerTx, peerRx;
   wire logic sckWire = sckOeN ? sckIn : sckOut;
   int errors = 0;
   int checksDone = 0;
   logic [6:0] fmts [7] = '{7'h08, 7'h1c, 7'h2f, 7'h30, 7'h49, 7'h70, 7'h5a};
   logic [15:0] words [7] = '{16'h00a5, 16'h0c3e, 16'h5a96, 16'hb1e7, 16'h01c3, 16'he4d2, 16'h0369};

   vlsio_top vlsio_top_i (.ref_clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .transferDoneIrq, .linkClk, .sckIn, .sckOut, .sckOeN, .siIn,
      .soOut, .soOeN);
   vlsio_peer vlsio_peer_i (.linkClk, .sck(sckWire), .so(soOut), .armed, .fmt(peerFmt),
      .txWord(peerTx), .si(siIn), .rxWord(peerRx));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      linkClk = 1'b0;
      #13;
      forever #40 linkClk = ~linkClk;
   end
   // ==========================================
   // bus and checking helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
   endtask
   task automatic waitIrq(input int lim, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(posedge ref_clk);
         if (transferDoneIrq === 1'b1) seen = 1'b1;
      end
   endtask
   // ==========================================
   // scenarios
   task automatic test_regs;
      logic [31:0] r;
      logic e;
      rd(vlsio_pkg::CTRL_OFF, r);
      chk(r, 32'h0000_0000);
      rd(vlsio_pkg::FMT_OFF, r);
      chk(r, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h0000_0001);
      $display("test regs done");
   endtask
   task automatic test_xfer(input logic [6:0] f, input logic [15:0] w, input logic rxo);
      int len;
      logic [15:0] mask;
      logic [31:0] r;
      logic seen;
      len = f[3:0] == 4'h0 ? 16 : (f[3] ? int'(f[3:0]) : 8);
      mask = 16'((32'h0000_0001 << len) - 1);
      wr(vlsio_pkg::FMT_OFF, 32'(f));
      // a polarity change moves the idle clock level; let it settle before arming
      repeat (12) @(posedge ref_clk);
      peerFmt <= f;
      peerTx <= ~w;
      armed <= 1'b1;
      if (rxo) rd(vlsio_pkg::DATA_OFF, r);
      else wr(vlsio_pkg::DATA_OFF, 32'(w));
      waitIrq(1000, seen);
      chk(32'(seen), 32'h0000_0001);
      if (!rxo) chk(32'(peerRx), 32'(w & mask));
      rd(vlsio_pkg::DATA_OFF, r);
      chk(r, 32'(~w & mask));
      if (rxo) waitIrq(1000, seen);
      if (rxo) chk(32'(seen), 32'h0000_0001);
      armed <= 1'b0;
      @(posedge ref_clk);
      $display("test xfer %h done", f);
   endtask
   task automatic test_disabled;
      logic seen;
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      chk(32'({sckOeN, soOeN}), 32'h0000_0003);
      wr(vlsio_pkg::DATA_OFF, 32'h0000_00a5);
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0081);
      waitIrq(400, seen);
      chk(32'(seen), 32'h0000_0000);
      $display("test disabled done");
   endtask
   task automatic test_abort;
      logic seen;
      wr(vlsio_pkg::DATA_OFF, 32'h0000_1234);
      repeat (60) @(posedge ref_clk);
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0001);
      repeat (20) @(posedge ref_clk);
      chk(32'({sckOeN, soOeN}), 32'h0000_0003);
      waitIrq(400, seen);
      chk(32'(seen), 32'h0000_0000);
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0081);
      $display("test abort done");
   endtask
   // external clock: the bench makes exactly one frame of edges, idle high between
   task automatic test_ext;
      logic [31:0] r;
      logic seen;
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0080);
      wr(vlsio_pkg::FMT_OFF, 32'h0000_0018);
      repeat (12) @(posedge ref_clk);
      peerFmt <= 7'h18;
      peerTx <= 16'h0096;
      armed <= 1'b1;
      wr(vlsio_pkg::DATA_OFF, 32'h0000_00e1);
      repeat (16) begin
         repeat (10) @(posedge ref_clk);
         sckIn <= ~sckIn;
      end
      waitIrq(40, seen);
      chk(32'(seen), 32'h0000_0001);
      chk(32'(peerRx), 32'h0000_00e1);
      rd(vlsio_pkg::DATA_OFF, r);
      chk(r, 32'h0000_0096);
      rd(vlsio_pkg::STAT_OFF, r);
      chk(r, 32'h0000_0002);
      wr(vlsio_pkg::STAT_OFF, 32'h0000_0002);
      rd(vlsio_pkg::STAT_OFF, r);
      chk(r, 32'h0000_0000);
      armed <= 1'b0;
      $display("test ext done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      {sys_rst, clkEn, sckIn} = 3'b111;
      {psel, penable, pwrite, armed} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      peerFmt = 7'h00;
      peerTx = 16'h0000;
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge ref_clk);
      test_regs();
      wr(vlsio_pkg::BAUD_OFF, 32'h0000_0004);
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0081);
      foreach (fmts[i]) test_xfer(fmts[i], words[i], 1'b0);
      wr(vlsio_pkg::CTRL_OFF, 32'h0000_0085);
      test_xfer(7'h1c, 16'h5a3c, 1'b1);
      test_disabled();
      test_abort();
      test_xfer(7'h08, 16'h00c3, 1'b0);
      test_ext();
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      errors++;
      print_verdict();
   end
endmodule // variable_length_serial_io_tb

// ---- vlsio_peer.sv ----
module vlsio_peer (
   input wire logic linkClk, // pattern clock
   input wire logic sck, // serial clock wire
   input wire logic so, // data from the device
   input wire logic armed, // frame expected
   input wire logic [6:0] fmt, // polarity, phase, order, length code
   input wire logic [15:0] txWord, // word sent to the device
   output logic si, // data to the device
   output logic [15:0] rxWord // word captured
);
   timeunit 1ns;
   timeprecision 1ns;
   int idx;
   int len;
   initial si = 1'b0;
   always_comb len = fmt[3:0] == 4'h0 ? 16 : (fmt[3] ? int'(fmt[3:0]) : 8);
   always @(posedge armed) begin
      idx = 0;
      rxWord = '0;
   end
   // capture on the sampling edge, then step to the next bit
   always @(sck) begin
      if (armed && idx < len && sck == (fmt[6] == fmt[5])) begin
         rxWord[fmt[4] ? len - 1 - idx : idx] = so;
         idx = idx + 1;
      end
   end
   // outside a frame the line shows a changing pattern
   always @(posedge linkClk) begin
      if (armed && idx < len) si <= txWord[fmt[4] ? len - 1 - idx : idx];
      else si <= ~si;
   end
endmodule // vlsio_peer

// ---- vlsio_props.sv ----
module vlsio_props (
   input wire logic ref_clk, // system clock
   input wire logic sys_rst, // reset
   input wire logic psel, // apb
   input wire logic penable, // apb
   input wire logic pwrite, // apb
   input wire logic pready, // apb
   input wire logic [7:0] paddr, // apb
   input wire logic [31:0] pwdata, // apb
   input wire logic transferDoneIrq, // done pulse
   input wire logic sckOut, // serial clock
   input wire logic sckOeN, // clock enable, low drives
   input wire logic soOut, // serial data
   input wire logic soOeN // data enable, low drives
);
   logic enQ, rxOnlyQ, cpolQ, dphQ, pendQ, sckPrevQ;
   logic [4:0] lenQ;
   logic [5:0] edgeCnt;
   logic [3:0] disCnt;
   wire logic acc = psel && penable && pready;
   wire logic wrCtrl = acc && pwrite && paddr == vlsio_pkg::CTRL_OFF;
   wire logic wrFmt = acc && pwrite && paddr == vlsio_pkg::FMT_OFF;
   wire logic start = acc && paddr == vlsio_pkg::DATA_OFF && enQ && !pendQ && pwrite != rxOnlyQ;
   // ==========================================
   // shadow of the settings
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         enQ <= 1'b0;
         rxOnlyQ <= 1'b0;
      end else if (wrCtrl) begin
         enQ <= pwdata[vlsio_pkg::CTRL_EN_BIT];
         rxOnlyQ <= pwdata[vlsio_pkg::CTRL_RXONLY_BIT];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cpolQ <= 1'b0;
         dphQ <= 1'b0;
         lenQ <= vlsio_pkg::LEN_FULL;
      end else if (wrFmt) begin
         cpolQ <= pwdata[vlsio_pkg::FMT_CPOL_BIT];
         dphQ <= pwdata[vlsio_pkg::FMT_DPHASE_BIT];
         lenQ <= pwdata[3:0] == 4'h0 ? 5'h10 : (pwdata[3] ? {1'b0, pwdata[3:0]} : 5'h08);
      end
   end
   // ==========================================
   // transfer tracking
   always_ff @(posedge ref_clk) begin
      if (sys_rst || (wrCtrl && !pwdata[vlsio_pkg::CTRL_EN_BIT])) pendQ <= 1'b0;
      else if (start) pendQ <= 1'b1;
      else if (transferDoneIrq) pendQ <= 1'b0;
   end
   always_ff @(posedge ref_clk) begin
      sckPrevQ <= sckOut;
      if (sys_rst || start) edgeCnt <= 6'h00;
      else if (pendQ && sckOut != sckPrevQ) edgeCnt <= edgeCnt + 6'h01;
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst || enQ) disCnt <= 4'h0;
      else if (disCnt != 4'hf) disCnt <= disCnt + 4'h1;
   end
   // ==========================================
   // properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence disableWr;
      wrCtrl && !pwdata[vlsio_pkg::CTRL_EN_BIT];
   endsequence
   sequence pinsReleased;
      sckOeN && soOeN;
   endsequence
   irq_pulse_a: assert property (transferDoneIrq |=> !transferDoneIrq)
      else $error("done pulse longer than one cycle");
   done_pending_a: assert property (transferDoneIrq |-> pendQ)
      else $error("done without a started transfer");
   xfer_bound_a: assert property (pendQ |-> ##[0:900] !pendQ)
      else $error("transfer never completes");
   edge_count_a: assert property (transferDoneIrq && !sckOeN |-> edgeCnt == 6'(2 * lenQ))
      else $error("wrong number of serial clock edges");
   idle_level_a: assert property (transferDoneIrq && !sckOeN |-> sckOut == !cpolQ)
      else $error("serial clock not at idle level after transfer");
   release_pins_a: assert property (disableWr |-> ##[1:20] pinsReleased)
      else $error("pins not released after disable");
   rx_only_so_a: assert property (wrCtrl && pwdata[7] && pwdata[2] |-> ##[1:20] soOeN [*4])
      else $error("serial out driven in receive-only mode");
   tx_drive_so_a: assert property (wrCtrl && pwdata[7] && !pwdata[2] |-> ##[1:20] !soOeN)
      else $error("serial out not driven in transmit mode");
   stopped_idle_a: assert property (disCnt == 4'hf |-> !transferDoneIrq && $stable(sckOut))
      else $error("activity while disabled");
   data_phase_a: assert property ($changed(soOut) && pendQ && !soOeN && edgeCnt != 6'h00 &&
      edgeCnt < 6'(2 * lenQ) |-> sckOut == (cpolQ ^ dphQ)) else $error("data changed on wrong edge");
endmodule // vlsio_props

bind vlsio_top vlsio_props vlsio_props_i (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .pready,
   .paddr, .pwdata, .transferDoneIrq, .sckOut, .sckOeN, .soOut, .soOeN);

// ---- vlsio_sync.sv ----
package vlsio_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] FMT_OFF = 8'h04;
   localparam logic [7:0] DATA_OFF = 8'h08;
   localparam logic [7:0] STAT_OFF = 8'h0C;
   localparam logic [7:0] BAUD_OFF = 8'h10;
   // ==========================================================
   // field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_RXONLY_BIT = 2;
   localparam int CTRL_INTCLK_BIT = 0;
   localparam int FMT_CPOL_BIT = 6;
   localparam int FMT_DPHASE_BIT = 5;
   localparam int FMT_MSB_BIT = 4;
   localparam int FMT_LEN_LSB = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int BAUD_K_LSB = 0;
   localparam int BAUD_N_LSB = 8;
   // ==========================================================
   // reset values and codes
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] FMT_RST = 8'h00;
   localparam logic [10:0] BAUD_RST = 11'h001;
   localparam logic [3:0] LEN_CODE_FULL = 4'h0;
   localparam logic [4:0] LEN_FULL = 5'h10;
   localparam logic [4:0] LEN_FALLBACK = 5'h08;
   localparam logic [15:0] DIV_ONE = 16'h0001;

   typedef struct packed {
      logic rxOnly;
      logic intClk;
      logic cpol;
      logic dphase;
      logic msbFirst;
      logic [3:0] lenCode;
      logic [2:0] divN;
      logic [7:0] divK;
   } vlsio_cfg_t;

   typedef enum logic {ENG_IDLE, ENG_SHIFT} vlsio_eng_t;
endpackage

module vlsio_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk, // destination clock
   input wire logic [WIDTH-1:0] asyncIn, // levels from another domain
   output logic [WIDTH-1:0] syncOut_q // levels after two flops
);
   logic [WIDTH-1:0] stage1_q;

   always_ff @(posedge clk) begin
      stage1_q <= asyncIn;
      syncOut_q <= stage1_q;
   end
endmodule // vlsio_sync

// ---- vlsio_top.sv ----
module vlsio_top (
   input wire logic ref_clk, // system clock, 25 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clkEn, // freezes all state but the synchronizer flops while low; sys_rst still resets
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   output logic transferDoneIrq, // one-cycle pulse per finished word
   input wire logic linkClk, // serial engine clock
   input wire logic sckIn, // serial clock pin, input side
   output logic sckOut, // serial clock pin, output side
   output logic sckOeN, // serial clock pin enable, low drives
   input wire logic siIn, // serial data in pin
   output logic soOut, // serial data out pin, output side
   output logic soOeN // serial data out pin enable, low drives
);
   // ==========================================================
   // apb side registers
   logic [7:0] ctrl_q;
   logic [7:0] fmt_q;
   logic [10:0] baud_q;
   logic [15:0] rxData_q;
   logic [15:0] txHold_q;
   logic busy_q;
   logic done_q;
   logic startTgl_q;
   logic doneSeen_q;
   logic [31:0] prdata_q;
   logic irq_q;
   vlsio_pkg::vlsio_cfg_t cfgNow;
   vlsio_pkg::vlsio_cfg_t cfgHold_q;

   logic setupPh;
   logic accessPh;
   logic addrHit;
   logic wrData;
   logic rdData;
   logic startReq;
   logic donePulse;
   logic doneSyncd;
   logic portEn;

   // ==========================================================
   // link side signals
   logic [8:0] linkSyncd;
   logic lCe;
   logic lRst;
   logic lEn;
   logic lStart;
   logic cpolS;
   logic intClkS;
   logic rxOnlyS;
   logic sckS;
   logic siS;
   vlsio_pkg::vlsio_eng_t state_q;
   vlsio_pkg::vlsio_cfg_t cfg_q;
   logic startSeen_q;
   logic [15:0] tx_q;
   logic [15:0] rx_q;
   logic [3:0] cnt_q;
   logic [14:0] div_q;
   logic sckDrv_q;
   logic sckPrev_q;
   logic so_q;
   logic sckOeN_q;
   logic soOeN_q;
   logic doneTgl_q;
   logic [4:0] lenBits;
   logic [3:0] lastIdx;
   logic [7:0] kEff;
   logic [14:0] halfLim;
   logic edgeNow;
   logic leadEdge;

   // ==========================================================
   // helpers
   function automatic logic [4:0] lenDecode(input logic [3:0] code);
      logic [4:0] len;
      len = vlsio_pkg::LEN_FALLBACK;
      if (code == vlsio_pkg::LEN_CODE_FULL) begin
         len = vlsio_pkg::LEN_FULL;
      end else if (code[3]) begin
         len = {1'b0, code};
      end
      return len;
   endfunction

   // position in the word of the i-th bit on the line
   function automatic logic [3:0] bitPos(input logic msb, input logic [4:0] len,
                                         input logic [3:0] i);
      logic [4:0] pos;
      pos = msb ? (len - 5'h01 - {1'b0, i}) : {1'b0, i};
      return pos[3:0];
   endfunction

   // ==========================================================
   // apb decode
   assign setupPh = psel & ~penable;
   assign accessPh = psel & penable & clkEn;
   assign pready = clkEn;
   assign prdata = prdata_q;
   assign transferDoneIrq = irq_q;
   assign portEn = ctrl_q[vlsio_pkg::CTRL_EN_BIT];

   always_comb begin
      case (paddr)
         vlsio_pkg::CTRL_OFF,
         vlsio_pkg::FMT_OFF,
         vlsio_pkg::DATA_OFF,
         vlsio_pkg::STAT_OFF,
         vlsio_pkg::BAUD_OFF: addrHit = 1'b1;
         default: addrHit = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~addrHit;
   assign wrData = accessPh & pwrite & (paddr == vlsio_pkg::DATA_OFF);
   assign rdData = accessPh & ~pwrite & (paddr == vlsio_pkg::DATA_OFF);

   assign cfgNow.rxOnly = ctrl_q[vlsio_pkg::CTRL_RXONLY_BIT];
   assign cfgNow.intClk = ctrl_q[vlsio_pkg::CTRL_INTCLK_BIT];
   assign cfgNow.cpol = fmt_q[vlsio_pkg::FMT_CPOL_BIT];
   assign cfgNow.dphase = fmt_q[vlsio_pkg::FMT_DPHASE_BIT];
   assign cfgNow.msbFirst = fmt_q[vlsio_pkg::FMT_MSB_BIT];
   assign cfgNow.lenCode = fmt_q[vlsio_pkg::FMT_LEN_LSB +: 4];
   assign cfgNow.divN = baud_q[vlsio_pkg::BAUD_N_LSB +: 3];
   assign cfgNow.divK = baud_q[vlsio_pkg::BAUD_K_LSB +: 8];

   // only an enabled, stopped port accepts the trigger of its mode
   assign startReq = portEn & ~busy_q &
                     ((~cfgNow.rxOnly & wrData) |
                      (cfgNow.rxOnly & rdData));

   // ==========================================================
   // configuration registers
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_q <= vlsio_pkg::CTRL_RST;
         fmt_q <= vlsio_pkg::FMT_RST;
         baud_q <= vlsio_pkg::BAUD_RST;
      end else if (accessPh & pwrite) begin
         case (paddr)
            vlsio_pkg::CTRL_OFF: ctrl_q <= pwdata[7:0] & 8'h85;
            vlsio_pkg::FMT_OFF: fmt_q <= pwdata[7:0] & 8'h7F;
            vlsio_pkg::BAUD_OFF: baud_q <= pwdata[10:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // transfer launch; data and format stay frozen while busy
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         startTgl_q <= 1'b0;
         txHold_q <= 16'h0000;
         cfgHold_q <= '0;
      end else if (clkEn) begin
         if (startReq) begin
            startTgl_q <= ~startTgl_q;
         end
         if (wrData & ~busy_q) begin
            txHold_q <= pwdata[15:0];
         end
         if (~busy_q) begin
            cfgHold_q <= cfgNow;
         end
      end
   end

   // ==========================================================
   // busy and done status
   assign donePulse = doneSyncd ^ doneSeen_q;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy_q <= 1'b0;
         doneSeen_q <= 1'b0;
         irq_q <= 1'b0;
         rxData_q <= 16'h0000;
      end else if (clkEn) begin
         doneSeen_q <= doneSyncd;
         irq_q <= donePulse;
         if (startReq) begin
            busy_q <= 1'b1;
         end else if (donePulse | ~portEn) begin
            busy_q <= 1'b0;
         end
         if (donePulse) begin
            rxData_q <= rx_q;
         end
      end
   end

   // a done event in the same cycle as a software clear keeps the flag
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (clkEn) begin
         if (donePulse) begin
            done_q <= 1'b1;
         end else if (accessPh & pwrite & (paddr == vlsio_pkg::STAT_OFF) &
                      pwdata[vlsio_pkg::STAT_DONE_BIT]) begin
            done_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read data, loaded in the setup phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata_q <= 32'h0000_0000;
      end else if (clkEn & setupPh) begin
         prdata_q <= 32'h0000_0000;
         case (paddr)
            vlsio_pkg::CTRL_OFF: prdata_q[7:0] <= ctrl_q;
            vlsio_pkg::FMT_OFF: prdata_q[7:0] <= fmt_q;
            vlsio_pkg::DATA_OFF: prdata_q[15:0] <= rxData_q;
            vlsio_pkg::STAT_OFF: begin
               prdata_q[vlsio_pkg::STAT_BUSY_BIT] <= busy_q;
               prdata_q[vlsio_pkg::STAT_DONE_BIT] <= done_q;
            end
            vlsio_pkg::BAUD_OFF: prdata_q[10:0] <= baud_q;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // crossings
   vlsio_sync #(
      .WIDTH(9)
   ) u_linkSync (
      .clk(linkClk),
      .asyncIn({clkEn, sys_rst, portEn, startTgl_q, cfgHold_q.cpol, cfgNow.intClk,
                cfgNow.rxOnly, sckIn, siIn}),
      .syncOut_q(linkSyncd)
   );

   vlsio_sync #(
      .WIDTH(1)
   ) u_refSync (
      .clk(ref_clk),
      .asyncIn(doneTgl_q),
      .syncOut_q(doneSyncd)
   );

   assign lCe = linkSyncd[8];
   assign lRst = linkSyncd[7];
   assign lEn = linkSyncd[6];
   assign lStart = linkSyncd[5];
   assign cpolS = linkSyncd[4];
   assign intClkS = linkSyncd[3];
   assign rxOnlyS = linkSyncd[2];
   assign sckS = linkSyncd[1];
   assign siS = linkSyncd[0];

   // ==========================================================
   // serial clock timing: half period is k * 2^n link cycles
   assign lenBits = lenDecode(cfg_q.lenCode);
   assign lastIdx = 4'(lenBits - 5'h01);
   assign kEff = (cfg_q.divK == 8'h00) ? vlsio_pkg::DIV_ONE[7:0] : cfg_q.divK;
   assign halfLim = 15'({7'h00, kEff} << cfg_q.divN);

   // internal clock: edge on divider wrap; external: edge on pin change
   assign edgeNow = (state_q == vlsio_pkg::ENG_SHIFT) &
                    (cfg_q.intClk ? (div_q == (halfLim - 15'h0001)) : (sckS != sckPrev_q));
   // leading edge leaves the idle level
   assign leadEdge = cfg_q.intClk ? (sckDrv_q == ~cfg_q.cpol) : (sckS == cfg_q.cpol);

   // ==========================================================
   // serial engine
   always_ff @(posedge linkClk) begin
      if (lRst) begin
         state_q <= vlsio_pkg::ENG_IDLE;
         startSeen_q <= 1'b0;
         cfg_q <= '0;
         tx_q <= 16'h0000;
         rx_q <= 16'h0000;
         cnt_q <= 4'h0;
         div_q <= 15'h0000;
         sckDrv_q <= 1'b1;
         sckPrev_q <= 1'b1;
         so_q <= 1'b0;
         doneTgl_q <= 1'b0;
      end else if (lCe) begin
         startSeen_q <= lStart;
         sckPrev_q <= sckS;
         if (~lEn) begin
            state_q <= vlsio_pkg::ENG_IDLE;
            cnt_q <= 4'h0;
            div_q <= 15'h0000;
            sckDrv_q <= ~cpolS;
         end else begin
            case (state_q)
               vlsio_pkg::ENG_IDLE: begin
                  sckDrv_q <= ~cpolS;
                  if (lStart != startSeen_q) begin
                     cfg_q <= cfgHold_q;
                     tx_q <= txHold_q;
                     rx_q <= 16'h0000;
                     cnt_q <= 4'h0;
                     div_q <= 15'h0000;
                     sckDrv_q <= ~cfgHold_q.cpol;
                     state_q <= vlsio_pkg::ENG_SHIFT;
                     // late phase puts the first bit out before the first edge
                     if (cfgHold_q.dphase) begin
                        so_q <= txHold_q[bitPos(cfgHold_q.msbFirst,
                                                lenDecode(cfgHold_q.lenCode), 4'h0)];
                     end
                  end
               end
               vlsio_pkg::ENG_SHIFT: begin
                  if (cfg_q.intClk) begin
                     div_q <= edgeNow ? 15'h0000 : div_q + 15'h0001;
                  end
                  if (edgeNow) begin
                     if (cfg_q.intClk) begin
                        sckDrv_q <= ~sckDrv_q;
                     end
                     if (leadEdge) begin
                        if (cfg_q.dphase) begin
                           rx_q[bitPos(cfg_q.msbFirst, lenBits, cnt_q)] <= siS;
                        end else begin
                           so_q <= tx_q[bitPos(cfg_q.msbFirst, lenBits, cnt_q)];
                        end
                     end else begin
                        if (~cfg_q.dphase) begin
                           rx_q[bitPos(cfg_q.msbFirst, lenBits, cnt_q)] <= siS;
                        end
                        if (cnt_q == lastIdx) begin
                           state_q <= vlsio_pkg::ENG_IDLE;
                           doneTgl_q <= ~doneTgl_q;
                        end else begin
                           cnt_q <= cnt_q + 4'h1;
                           if (cfg_q.dphase) begin
                              so_q <= tx_q[bitPos(cfg_q.msbFirst, lenBits,
                                                  cnt_q + 4'h1)];
                           end
                        end
                     end
                  end
               end
               default: state_q <= vlsio_pkg::ENG_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // pin enables
   always_ff @(posedge linkClk) begin
      if (lRst) begin
         sckOeN_q <= 1'b1;
         soOeN_q <= 1'b1;
      end else if (lCe) begin
         sckOeN_q <= ~(lEn & intClkS);
         soOeN_q <= ~(lEn & ~rxOnlyS);
      end
   end

   assign sckOut = sckDrv_q;
   assign sckOeN = sckOeN_q;
   assign soOut = so_q;
   assign soOeN = soOeN_q;
endmodule // vlsio_top
